// ---- rtl/cssel_pkg.sv ----
// Package for the clock source and start-up delay selection block.
// Assumes one clock domain at 125 MHz; fuse values arrive as static levels.
package cssel_pkg;

	// ---------------------------------------------------------------
	// Fuse encodings
	// ---------------------------------------------------------------
	localparam logic [3:0] CSSEL_EXT_CLK   = 4'h0;
	localparam logic [3:0] CSSEL_RC_CAL    = 4'h2;
	localparam logic [3:0] CSSEL_RC_128K   = 4'h3;
	localparam logic [3:0] CSSEL_LF_FAST   = 4'h4;
	localparam logic [3:0] CSSEL_LF_SLOW   = 4'h5;
	localparam logic [3:0] CSSEL_LF_XTAL_A = 4'h6;
	localparam logic [3:0] CSSEL_LF_XTAL_B = 4'h7;
	localparam logic [1:0] CSSEL_SUT_NONE  = 2'h0;
	localparam logic [1:0] CSSEL_SUT_SHORT = 2'h1;
	localparam logic [1:0] CSSEL_SUT_LONG  = 2'h2;
	localparam logic [1:0] CSSEL_SUT_RSVD  = 2'h3;

	// ---------------------------------------------------------------
	// Shipped defaults and reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] CSSEL_DEF_SRC   = CSSEL_RC_CAL;
	localparam logic [1:0] CSSEL_DEF_SUT   = CSSEL_SUT_LONG;
	localparam logic       CSSEL_DEF_DIV8  = 1'b0;
	localparam logic [7:0] CSSEL_TRIM_RST  = 8'h00;
	localparam logic [3:0] CSSEL_PRESC_D1  = 4'h0;
	localparam logic [3:0] CSSEL_PRESC_D8  = 4'h3;

	// ---------------------------------------------------------------
	// Cycle counts
	// ---------------------------------------------------------------
	localparam logic [15:0] CSSEL_CK_RESET  = 16'h0013;
	localparam logic [15:0] CSSEL_CK_WAKE6  = 16'h0006;
	localparam logic [15:0] CSSEL_CK_WAKE1K = 16'h0400;
	localparam logic [15:0] CSSEL_CK_WAKE32K = 16'h8000;
	localparam logic [13:0] CSSEL_WDT_NONE  = 14'h0000;
	localparam logic [13:0] CSSEL_WDT_SHORT = 14'h0200;
	localparam logic [13:0] CSSEL_WDT_LONG  = 14'h2000;
	localparam int          CSSEL_SYNC_LEN  = 2;

	// ---------------------------------------------------------------
	// Types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CSSEL_ST_IDLE    = 3'b000,
		CSSEL_ST_TIMEOUT = 3'b001,
		CSSEL_ST_START   = 3'b010,
		CSSEL_ST_RUN     = 3'b011,
		CSSEL_ST_SLEEP   = 3'b100
	} cssel_state_e;

	typedef struct packed {
		logic [3:0] clock_source_select_fuses;
		logic [1:0] startup_delay_fuses;
		logic       divide_by_eight_fuse;
		logic       reset_pin_disable_fuse;
	} cssel_fuse_s;

	typedef struct packed {
		logic       src_ext;
		logic       src_rc_cal;
		logic       src_rc_128k;
		logic       src_lf_xtal;
	} cssel_src_s;

endpackage : cssel_pkg

// ---- rtl/cssel_tick_sync.sv ----
// Two-stage synchroniser with rising edge pulse for an asynchronous clock.
// Assumes the sampled clock is well below half of clk.
`timescale 1ns/10ps
module cssel_tick_sync (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Asynchronous clock in, one-cycle pulse out
	input  wire logic async_in,
	output logic      rise_pulse
);
	logic meta_r;
	logic sync_r;
	logic last_r;

	// The chain keeps sampling through reset, so the edge memory already
	// holds the pin level at release and a source that is high then does
	// not count a phantom cycle.
	always_ff @(posedge clk) begin
		meta_r <= async_in;
		sync_r <= meta_r;
		last_r <= sync_r;
	end

	assign rise_pulse = sync_r & ~last_r & ~rst;

endmodule : cssel_tick_sync

// ---- rtl/cssel_clock_startup.sv ----
// Clock source selection and start-up delay sequencer.
// Assumes fuses are static, oscillators arrive as raw levels on pins and
// a reset request and power-down wake request come from the same domain.
// How it works
// - Fuse 0100 to 0111 selects watch crystal.
// - Crystal wake counts: 0100 1K, 0101 32K.
// - Crystal reset delay 19, +4.1ms, +65ms.
// - Fuse 0010 selects calibrated RC oscillator.
// - Shipped default divides RC clock by eight.
// - Reset loads factory value into trim register.
// - Software may overwrite the trim register.
// - RC source waits 6 cycles on wake.
// - Reset pin disabled lengthens shortest delay of RC and 128kHz sources.
// - Watchdog oscillator always times reset time-out.
// - Fuse 0011 selects 128kHz internal oscillator.
// - 128kHz source waits 6 cycles on wake.
// - Fuse 0000 selects external clock input.
// - External clock waits 6 cycles on wake.
// - Time-out counts 0, 512 or 8192 cycles.
// - Wake applies start-up count, no time-out.
`timescale 1ns/10ps
module cssel_clock_startup (
	// Clock and reset
	input  wire logic                  clk,
	input  wire logic                  rst,
	// Fuses
	input  wire cssel_pkg::cssel_fuse_s fuses,
	input  wire logic [7:0]            factory_trim,
	// Oscillator outputs seen as raw levels
	input  wire logic                  crystal_input_pin,
	input  wire logic                  timer_osc_input_pin,
	input  wire logic                  rc_cal_osc,
	input  wire logic                  rc_128k_osc,
	input  wire logic                  watchdog_osc,
	// Power control
	input  wire logic                  sleep_enter,
	input  wire logic                  wake_request,
	// Trim write port
	input  wire logic                  trim_wr,
	input  wire logic [7:0]            trim_wdata,
	// Status and selection outputs
	output cssel_pkg::cssel_src_s      src_sel,
	output logic [7:0]                 rc_trim_register,
	output logic [3:0]                 prescale_init,
	output logic                       internal_reset,
	output logic                       fuse_reserved
);
	// ---------------------------------------------------------------
	// Source decode
	// ---------------------------------------------------------------
	logic [3:0] src_f;
	logic [1:0] sut_f;
	logic       sel_lf;
	logic       sel_rc;
	logic       sel_128;
	logic       sel_ext;
	logic       src_tick;
	logic       wdt_tick;
	logic       xtal_tick;
	logic       tosc_tick;
	logic       rc_tick;
	logic       k128_tick;

	assign src_f   = fuses.clock_source_select_fuses;
	assign sut_f   = fuses.startup_delay_fuses;
	assign sel_lf  = (src_f == cssel_pkg::CSSEL_LF_XTAL_A) |
	                 (src_f == cssel_pkg::CSSEL_LF_XTAL_B) |
	                 (src_f == cssel_pkg::CSSEL_LF_FAST) |
	                 (src_f == cssel_pkg::CSSEL_LF_SLOW);
	assign sel_rc  = (src_f == cssel_pkg::CSSEL_RC_CAL);
	assign sel_128 = (src_f == cssel_pkg::CSSEL_RC_128K);
	assign sel_ext = (src_f == cssel_pkg::CSSEL_EXT_CLK);

	// Rising edges of each source, sampled on clk.
	cssel_tick_sync u_sync_xtal (
		.clk        (clk),
		.rst        (rst),
		.async_in   (crystal_input_pin),
		.rise_pulse (xtal_tick)
	);
	cssel_tick_sync u_sync_tosc (
		.clk        (clk),
		.rst        (rst),
		.async_in   (timer_osc_input_pin),
		.rise_pulse (tosc_tick)
	);
	cssel_tick_sync u_sync_rc (
		.clk        (clk),
		.rst        (rst),
		.async_in   (rc_cal_osc),
		.rise_pulse (rc_tick)
	);
	cssel_tick_sync u_sync_128 (
		.clk        (clk),
		.rst        (rst),
		.async_in   (rc_128k_osc),
		.rise_pulse (k128_tick)
	);
	cssel_tick_sync u_sync_wdt (
		.clk        (clk),
		.rst        (rst),
		.async_in   (watchdog_osc),
		.rise_pulse (wdt_tick)
	);

	// The crystal and timer oscillator share a pin pair; the watch
	// crystal is taken from either side of it.
	assign src_tick = sel_ext ? xtal_tick :
	                  sel_rc  ? rc_tick :
	                  sel_128 ? k128_tick :
	                  sel_lf  ? (xtal_tick | tosc_tick) : 1'b0;

	// ---------------------------------------------------------------
	// Count selection
	// ---------------------------------------------------------------
	logic [13:0] wdt_target;
	logic [15:0] wake_target;
	logic [1:0]  sut_eff;

	always_comb begin
		sut_eff = sut_f;
		if (fuses.reset_pin_disable_fuse == 1'b0 && sut_f == cssel_pkg::CSSEL_SUT_NONE &&
		    (sel_rc || sel_128)) begin
			sut_eff = cssel_pkg::CSSEL_SUT_SHORT;
		end
	end

	always_comb begin
		case (sut_eff)
			cssel_pkg::CSSEL_SUT_SHORT: wdt_target = cssel_pkg::CSSEL_WDT_SHORT;
			cssel_pkg::CSSEL_SUT_LONG:  wdt_target = cssel_pkg::CSSEL_WDT_LONG;
			default:                    wdt_target = cssel_pkg::CSSEL_WDT_NONE;
		endcase
	end

	always_comb begin
		if (src_f == cssel_pkg::CSSEL_LF_SLOW) begin
			wake_target = cssel_pkg::CSSEL_CK_WAKE32K;
		end else if (sel_lf) begin
			wake_target = cssel_pkg::CSSEL_CK_WAKE1K;
		end else begin
			wake_target = cssel_pkg::CSSEL_CK_WAKE6;
		end
	end

	assign fuse_reserved = (sut_f == cssel_pkg::CSSEL_SUT_RSVD) |
	                       ~(sel_lf | sel_rc | sel_128 | sel_ext);

	// ---------------------------------------------------------------
	// Start-up sequencer
	// ---------------------------------------------------------------
	cssel_pkg::cssel_state_e state_r;
	logic [13:0]             wdt_cnt_r;
	logic [15:0]             ck_cnt_r;
	logic [15:0]             ck_target_r;

	// The reset time-out runs on the watchdog oscillator only; the chosen
	// source changes only its length, as RC and 128kHz sources lengthen
	// the shortest delay when the reset pin is disabled; the extra 19 source cycles follow.
	always_ff @(posedge clk) begin
		if (rst) begin
			state_r     <= cssel_pkg::CSSEL_ST_IDLE;
			wdt_cnt_r   <= 14'h0000;
			ck_cnt_r    <= 16'h0000;
			ck_target_r <= cssel_pkg::CSSEL_CK_RESET;
		end else begin
			case (state_r)
				cssel_pkg::CSSEL_ST_IDLE: begin
					wdt_cnt_r   <= 14'h0000;
					ck_cnt_r    <= 16'h0000;
					ck_target_r <= cssel_pkg::CSSEL_CK_RESET;
					state_r     <= cssel_pkg::CSSEL_ST_TIMEOUT;
				end
				cssel_pkg::CSSEL_ST_TIMEOUT: begin
					if (wdt_cnt_r >= wdt_target) begin
						state_r <= cssel_pkg::CSSEL_ST_START;
					end else if (wdt_tick) begin
						wdt_cnt_r <= wdt_cnt_r + 14'h0001;
					end
				end
				cssel_pkg::CSSEL_ST_START: begin
					if (ck_cnt_r >= ck_target_r) begin
						state_r <= cssel_pkg::CSSEL_ST_RUN;
					end else if (src_tick) begin
						ck_cnt_r <= ck_cnt_r + 16'h0001;
					end
				end
				cssel_pkg::CSSEL_ST_RUN: begin
					if (sleep_enter) begin
						state_r <= cssel_pkg::CSSEL_ST_SLEEP;
					end
				end
				cssel_pkg::CSSEL_ST_SLEEP: begin
					if (wake_request) begin
						ck_cnt_r    <= 16'h0000;
						ck_target_r <= wake_target;
						state_r     <= cssel_pkg::CSSEL_ST_START;
					end
				end
				default: begin
					state_r <= cssel_pkg::CSSEL_ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			internal_reset <= 1'b1;
		end else begin
			internal_reset <= (state_r != cssel_pkg::CSSEL_ST_RUN) &&
			                  (state_r != cssel_pkg::CSSEL_ST_SLEEP);
		end
	end

	// ---------------------------------------------------------------
	// Trim register, prescaler start value and source outputs
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (rst) begin
			rc_trim_register <= cssel_pkg::CSSEL_TRIM_RST;
		end else if (internal_reset) begin
			rc_trim_register <= factory_trim;
		end else if (trim_wr) begin
			rc_trim_register <= trim_wdata;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			prescale_init <= cssel_pkg::CSSEL_PRESC_D8;
			src_sel       <= '0;
		end else begin
			prescale_init <= (fuses.divide_by_eight_fuse == 1'b0) ?
			                 cssel_pkg::CSSEL_PRESC_D8 : cssel_pkg::CSSEL_PRESC_D1;
			src_sel.src_ext     <= sel_ext;
			src_sel.src_rc_cal  <= sel_rc;
			src_sel.src_rc_128k <= sel_128;
			src_sel.src_lf_xtal <= sel_lf;
		end
	end

endmodule : cssel_clock_startup

// ---- verification/cssel_osc_model.sv ----
// Free-running oscillator on one pin, with a tally of its rising edges.
// Assumes the half period stays above two periods of clk.
`timescale 1ns/10ps
module cssel_osc_model #(parameter int HALF_NS = 40) (
	// Pin level and edge tally
	output logic osc,
	output int   edges
);
	// A fixed half period keeps cycle-to-cycle drift at zero.
	initial begin
		osc = 1'b0;
		edges = 0;
		forever begin
			#HALF_NS osc = ~osc;
			if (osc) edges++;
		end
	end
endmodule : cssel_osc_model

// ---- verification/cssel_asserts.sv ----
// Port assertions for the clock source start-up sequencer.
// Assumes it is bound to cssel_clock_startup.
`timescale 1ns/10ps
module cssel_asserts (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   rst,
	// Watched ports
	input wire cssel_pkg::cssel_fuse_s fuses,
	input wire logic [7:0]             factory_trim,
	input wire logic                   trim_wr,
	input wire logic [7:0]             trim_wdata,
	input wire cssel_pkg::cssel_src_s  src_sel,
	input wire logic [7:0]             rc_trim_register,
	input wire logic [3:0]             prescale_init,
	input wire logic                   internal_reset,
	input wire logic                   fuse_reserved
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	property p_hold; $fell(rst) |-> internal_reset [*8]; endproperty
	a_hold: assert property (p_hold) else $error("reset released early");
	property p_load; internal_reset |=> rc_trim_register == $past(factory_trim); endproperty
	a_load: assert property (p_load) else $error("trim not loaded");
	property p_wr; !internal_reset && trim_wr |=> rc_trim_register == $past(trim_wdata); endproperty
	a_wr: assert property (p_wr) else $error("trim write lost");
	property p_keep; !internal_reset && !trim_wr |=> $stable(rc_trim_register); endproperty
	a_keep: assert property (p_keep) else $error("trim changed");
	property p_div; !internal_reset |->
		prescale_init == (fuses.divide_by_eight_fuse ? 4'h0 : 4'h3); endproperty
	a_div: assert property (p_div) else $error("prescale wrong");
	property p_ext; !internal_reset |->
		src_sel.src_ext == (fuses.clock_source_select_fuses == 4'h0); endproperty
	a_ext: assert property (p_ext) else $error("ext select wrong");
	property p_rc; !internal_reset |->
		src_sel.src_rc_cal == (fuses.clock_source_select_fuses == 4'h2); endproperty
	a_rc: assert property (p_rc) else $error("rc select wrong");
	property p_slow; !internal_reset |->
		src_sel.src_rc_128k == (fuses.clock_source_select_fuses == 4'h3); endproperty
	a_slow: assert property (p_slow) else $error("128k select wrong");
	property p_lf; !internal_reset |->
		src_sel.src_lf_xtal == (fuses.clock_source_select_fuses inside {[4'h4:4'h7]}); endproperty
	a_lf: assert property (p_lf) else $error("crystal select wrong");
	property p_rsv; fuses.startup_delay_fuses == 2'h3 |-> fuse_reserved; endproperty
	a_rsv: assert property (p_rsv) else $error("reserved not flagged");
endmodule : cssel_asserts
bind cssel_clock_startup cssel_asserts i_cssel_asserts (.clk(clk), .rst(rst), .fuses(fuses),
	.factory_trim(factory_trim), .trim_wr(trim_wr), .trim_wdata(trim_wdata), .src_sel(src_sel),
	.rc_trim_register(rc_trim_register), .prescale_init(prescale_init),
	.internal_reset(internal_reset), .fuse_reserved(fuse_reserved));

// ---- verification/testbench.sv ----
// Self-checking bench for the clock source start-up sequencer.
// Assumes fuses change only while rst is high.
`timescale 1ns/10ps
module testbench;
	logic clk, rst, sleep_enter, wake_request, trim_wr, internal_reset, fuse_reserved;
	logic xtal, rc, r128, wdt;
	logic [7:0] factory_trim, trim_wdata, rc_trim_register;
	logic [3:0] prescale_init;
	logic [3:0] codes [5] = '{4'h0, 4'h3, 4'h4, 4'h6, 4'h7};
	logic [3:0] exp_src [5] = '{4'h8, 4'h2, 4'h1, 4'h1, 4'h1};
	cssel_pkg::cssel_fuse_s fuses;
	cssel_pkg::cssel_src_s src_sel;
	int e_xtal, e_rc, e_r128, e_wdt, n_errors, comparisons;
	cssel_osc_model #(.HALF_NS(40)) i_xtal (.osc(xtal), .edges(e_xtal));
	cssel_osc_model #(.HALF_NS(44)) i_rc (.osc(rc), .edges(e_rc));
	cssel_osc_model #(.HALF_NS(48)) i_r128 (.osc(r128), .edges(e_r128));
	cssel_osc_model #(.HALF_NS(20)) i_wdt (.osc(wdt), .edges(e_wdt));
	cssel_clock_startup i_cssel_clock_startup (.clk(clk), .rst(rst), .fuses(fuses),
		.factory_trim(factory_trim), .crystal_input_pin(xtal), .timer_osc_input_pin(xtal),
		.rc_cal_osc(rc), .rc_128k_osc(r128), .watchdog_osc(wdt), .sleep_enter(sleep_enter),
		.wake_request(wake_request), .trim_wr(trim_wr), .trim_wdata(trim_wdata),
		.src_sel(src_sel), .rc_trim_register(rc_trim_register),
		.prescale_init(prescale_init), .internal_reset(internal_reset),
		.fuse_reserved(fuse_reserved));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	task automatic check(input logic [15:0] seen, input logic [15:0] expected);
		comparisons++;
		if (seen !== expected) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h expected=%h", $time, seen, expected);
		end
	endtask : check
	// A count inside its window is reported as itself, outside as a miss.
	task automatic rng(input int v, input int lo, input int hi);
		check(16'(v), (v >= lo && v <= hi) ? 16'(v) : 16'(lo));
	endtask : rng
	function automatic int src_cnt();
		case (fuses.clock_source_select_fuses)
			4'h2: return e_rc;
			4'h3: return e_r128;
			default: return e_xtal;
		endcase
	endfunction : src_cnt
	task automatic wait_run();
		for (int i = 0; i < 50000 && internal_reset !== 1'b0; i++)
			@(negedge clk);
		check(internal_reset, 1'b0);
	endtask : wait_run
	// A trim write is offered at release, where it must be refused.
	task automatic boot(input logic [7:0] f, input int wlo, input int whi);
		int w;
		int s;
		fuses = f;
		rst = 1'b1;
		repeat (10) @(negedge clk);
		// Tallies start early enough to cover the synchroniser delay.
		w = e_wdt;
		s = src_cnt();
		repeat (2) @(negedge clk);
		check(internal_reset, 1'b1);
		rst = 1'b0;
		trim_wr = 1'b1;
		@(negedge clk);
		trim_wr = 1'b0;
		wait_run();
		rng(e_wdt - w, wlo, whi);
		if (wlo == 0) rng(src_cnt() - s, 19, 22);
		check(rc_trim_register, factory_trim);
		check(fuse_reserved, f[3:2] == 2'h3);
	endtask : boot
	task automatic wake(input int lo, input int hi);
		int s;
		sleep_enter = 1'b1;
		repeat (2) @(negedge clk);
		s = src_cnt();
		repeat (2) @(negedge clk);
		sleep_enter = 1'b0;
		wake_request = 1'b1;
		repeat (2) @(negedge clk);
		wake_request = 1'b0;
		wait_run();
		rng(src_cnt() - s, lo, hi);
	endtask : wake
	task automatic print_verdict();
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : print_verdict
	initial begin
		{rst, fuses, factory_trim, trim_wdata} = {1'b1, 8'h29, 8'hc3, 8'h3c};
		{sleep_enter, wake_request, trim_wr} = 3'h0;
		n_errors = 0;
		comparisons = 0;
		@(negedge clk);
		boot(8'h29, 8192, 8245);
		check(prescale_init, 4'h3);
		check(src_sel, 4'h4);
		trim_wdata = 8'h5a;
		trim_wr = 1'b1;
		@(negedge clk);
		trim_wr = 1'b0;
		@(negedge clk);
		check(rc_trim_register, 8'h5a);
		wake(6, 8);
		$display("test shipped default done");
		foreach (codes[k]) begin
			boot({codes[k], 4'h3}, 0, 50);
			check(src_sel, exp_src[k]);
			check(prescale_init, 4'h0);
			wake(codes[k][2] ? 1024 : 6, codes[k][2] ? 1027 : 8);
			$display("test source %h done", codes[k]);
		end
		boot(8'h22, 512, 565);
		boot(8'h37, 512, 565);
		boot(8'h2f, 0, 50);
		boot(8'h53, 0, 50);
		check(src_sel, 4'h1);
		check(prescale_init, 4'h0);
		rst = 1'b1;
		fuses = 8'h13;
		#1;
		check(fuse_reserved, 1'b1);
		$display("test delays and reserved fields done");
		print_verdict();
	end
	initial begin
		#800000;
		n_errors++;
		print_verdict();
	end
endmodule : testbench
